// ===== receive_side_mac_pkg.sv
// Shared constants, states and carriers of the receive address match and statistics block
package receive_side_mac_pkg;

   // ************************************************************
   // Register byte addresses
   // ************************************************************
   localparam logic [31:0] STATION_ADDR_LOW_ADDR       = 32'h08c0_6320;
   localparam logic [31:0] GOOD_FRAME_COUNT_ADDR       = 32'h08c0_6324;
   localparam logic [31:0] OVERSIZE_FRAME_COUNT_ADDR   = 32'h08c0_6328;
   localparam logic [31:0] MISALIGNED_FRAME_COUNT_ADDR = 32'h08c0_632c;
   localparam logic [31:0] CRC_FAIL_COUNT_ADDR         = 32'h08c0_6330;
   localparam logic [31:0] RX_FSM_SNAPSHOT_ADDR        = 32'h08c0_6334;
   localparam logic [31:0] SYMBOL_ERROR_COUNT_ADDR     = 32'h08c0_6338;
   localparam logic [31:0] MCAST_TABLE_WORD3_ADDR      = 32'h08c0_6340;
   localparam logic [31:0] MCAST_TABLE_WORD2_ADDR      = 32'h08c0_6344;
   localparam logic [31:0] MCAST_TABLE_WORD1_ADDR      = 32'h08c0_6348;
   localparam logic [31:0] MCAST_TABLE_WORD0_ADDR      = 32'h08c0_634c;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int          SNAP_PROTO_LSB          = 0;
   localparam int          SNAP_PAD_LSB            = 5;
   localparam logic [15:0] STATION_ADDR_LOW_RST    = 16'h0000;
   localparam logic [15:0] MCAST_TABLE_WORD_RST    = 16'h0000;
   localparam logic [12:0] LONGEST_FRAME_BYTES_RST = 13'h05ee;

   // ************************************************************
   // Frame format and checksum constants
   // ************************************************************
   localparam logic [3:0]  SFD_NIBBLE      = 4'hd;
   localparam logic [14:0] DA_NIBBLES      = 15'h000c;
   localparam logic [13:0] DA_BYTES        = 14'h0006;
   localparam logic [13:0] PAD_LIMIT_BYTES = 14'h0040;
   localparam logic [31:0] CRC_POLY_REFL   = 32'hedb8_8320;
   localparam logic [31:0] CRC_INIT        = 32'hffff_ffff;
   localparam logic [31:0] CRC_RESIDUE     = 32'hdebb_20e3;

   // ************************************************************
   // State machines and carriers
   // ************************************************************
   typedef enum logic [4:0] {
      PROTO_IDLE     = 5'h00,
      PROTO_PREAMBLE = 5'h01,
      PROTO_DATA     = 5'h02,
      PROTO_FINISH   = 5'h03
   } proto_state_e;

   typedef enum logic [1:0] {
      PAD_IDLE  = 2'h0,
      PAD_SHORT = 2'h1,
      PAD_FULL  = 2'h2
   } pad_state_e;

   typedef struct packed {
      logic        sel;
      logic        wr;
      logic [31:0] addr;
      logic [15:0] wdata;
   } pio_req_s;

endpackage

// ===== rx_crc32_nibble.sv
// Running frame checksum, fed one receive nibble per cycle
module rx_crc32_nibble
   import receive_side_mac_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        init_i,
   input  wire logic        en_i,
   input  wire logic [3:0]  nibble_i,
   output logic      [31:0] crc_o
);

   // ************************************************************
   // Nibble update, least significant bit first on the wire
   // ************************************************************
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [3:0] d);
      logic [31:0] r;
      logic        fb;
      r = c;
      for (int i = 0; i < 4; i++) begin
         fb = r[0] ^ d[i];
         r  = r >> 1;
         if (fb) begin
            r = r ^ CRC_POLY_REFL;
         end
      end
      return r;
   endfunction

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         crc_o <= CRC_INIT;
      end else if (init_i) begin
         crc_o <= CRC_INIT;
      end else if (en_i) begin
         crc_o <= crc_step(crc_o, nibble_i);
      end
   end

endmodule

// ===== rx_stat_counter.sv
// Loadable wrapping statistics counter
module rx_stat_counter #(
   parameter int WIDTH = 8
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             load_i,
   input  wire logic [WIDTH-1:0] load_val_i,
   input  wire logic             inc_i,
   output logic      [WIDTH-1:0] count_o
);

   // A load and an event in one cycle keep both: the event adds to the loaded value
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_o <= '0;
      end else if (load_i) begin
         count_o <= load_val_i + WIDTH'(inc_i);
      end else if (inc_i) begin
         count_o <= count_o + WIDTH'(1'b1);
      end
   end

endmodule

// ===== receive_side_mac_stats.sv
// Receive side MAC: destination address match, multicast hash filter and statistics
module receive_side_mac_stats
   import receive_side_mac_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire pio_req_s    pio_req_i,
   output logic      [15:0] pio_rdata_o,
   output logic             pio_ack_o,
   input  wire logic        mii_rx_dv_i,
   input  wire logic        mii_rx_er_i,
   input  wire logic [3:0]  mii_rxd_i,
   input  wire logic [31:0] station_addr_high_i,
   input  wire logic [12:0] longest_frame_bytes_i,
   input  wire logic        hash_filter_en_i,
   output logic             frame_done_o,
   output logic             frame_accept_o
);

   // ************************************************************
   // Declarations
   // ************************************************************
   proto_state_e proto_reg;
   proto_state_e proto_next;
   pad_state_e   pad_reg;
   logic [15:0]  station_addr_low_reg;
   logic [63:0]  mcast_table_reg;
   logic [14:0]  nib_cnt_reg;
   logic [3:0]   low_nib_reg;
   logic [47:0]  da_reg;
   logic [5:0]   hash_idx_reg;
   logic         viol_reg;
   logic [31:0]  crc;
   logic         crc_init;
   logic         crc_en;
   logic [13:0]  byte_cnt;
   logic         byte_done;
   logic         frame_end;
   logic         crc_bad;
   logic         odd_nibbles;
   logic         too_long;
   logic         ev_good;
   logic         ev_long;
   logic         ev_align;
   logic         ev_fcs;
   logic         ev_viol;
   logic         wr_en;
   logic         ld_good;
   logic         ld_long;
   logic         ld_align;
   logic         ld_fcs;
   logic         ld_viol;
   logic [15:0]  good_cnt;
   logic [7:0]   long_cnt;
   logic [7:0]   align_cnt;
   logic [7:0]   fcs_cnt;
   logic [7:0]   viol_cnt;
   logic         da_match;
   logic         mcast;
   logic         bcast;
   logic         accept;

   // ************************************************************
   // Receive protocol machine
   // ************************************************************
   always_comb begin
      proto_next = proto_reg;
      case (proto_reg)
         PROTO_IDLE: begin
            if (mii_rx_dv_i) begin
               proto_next = PROTO_PREAMBLE;
            end
         end
         PROTO_PREAMBLE: begin
            if (!mii_rx_dv_i) begin
               proto_next = PROTO_IDLE;
            end else if (mii_rxd_i == SFD_NIBBLE) begin
               proto_next = PROTO_DATA;
            end
         end
         PROTO_DATA: begin
            if (!mii_rx_dv_i) begin
               proto_next = PROTO_FINISH;
            end
         end
         PROTO_FINISH: begin
            proto_next = PROTO_IDLE;
         end
         default: begin
            proto_next = PROTO_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         proto_reg <= PROTO_IDLE;
      end else begin
         proto_reg <= proto_next;
      end
   end

   // ************************************************************
   // Nibble assembly and destination address capture
   // ************************************************************
   assign crc_init  = (proto_reg == PROTO_PREAMBLE) && (proto_next == PROTO_DATA);
   assign crc_en    = (proto_reg == PROTO_DATA) && mii_rx_dv_i;
   assign byte_done = crc_en && nib_cnt_reg[0];
   assign byte_cnt  = nib_cnt_reg[14:1];
   assign frame_end = (proto_reg == PROTO_DATA) && !mii_rx_dv_i;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         nib_cnt_reg <= '0;
         low_nib_reg <= '0;
      end else if (crc_init) begin
         nib_cnt_reg <= '0;
      end else if (crc_en) begin
         // Saturate: a runaway frame must not wrap back under the size limit
         if (nib_cnt_reg != '1) begin
            nib_cnt_reg <= nib_cnt_reg + 15'h0001;
         end
         low_nib_reg <= mii_rxd_i;
      end
   end

   // First byte on the wire lands in bits 47..40
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         da_reg <= '0;
      end else if (byte_done && (byte_cnt < DA_BYTES)) begin
         da_reg <= {da_reg[39:0], mii_rxd_i, low_nib_reg};
      end
   end

   rx_crc32_nibble u_crc (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .init_i    (crc_init),
      .en_i      (crc_en),
      .nibble_i  (mii_rxd_i),
      .crc_o     (crc)
   );

   // Checksum just after the twelfth nibble covers exactly the destination address
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hash_idx_reg <= '0;
      end else if ((proto_reg == PROTO_DATA) && (nib_cnt_reg == DA_NIBBLES)) begin
         hash_idx_reg <= crc[5:0];
      end
   end

   // Receive error is remembered for the frame and counted once at its end
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         viol_reg <= 1'b0;
      end else if (mii_rx_dv_i && mii_rx_er_i) begin
         viol_reg <= 1'b1;
      end else if (proto_reg == PROTO_IDLE) begin
         viol_reg <= 1'b0;
      end
   end

   // ************************************************************
   // Pad machine
   // ************************************************************
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pad_reg <= PAD_IDLE;
      end else begin
         case (pad_reg)
            PAD_IDLE: begin
               if (crc_init) begin
                  pad_reg <= PAD_SHORT;
               end
            end
            PAD_SHORT: begin
               if (proto_reg != PROTO_DATA) begin
                  pad_reg <= PAD_IDLE;
               end else if (byte_cnt >= PAD_LIMIT_BYTES) begin
                  pad_reg <= PAD_FULL;
               end
            end
            PAD_FULL: begin
               if (proto_reg != PROTO_DATA) begin
                  pad_reg <= PAD_IDLE;
               end
            end
            default: begin
               pad_reg <= PAD_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Frame classification
   // ************************************************************
   assign crc_bad     = (crc != CRC_RESIDUE);
   assign odd_nibbles = nib_cnt_reg[0];
   assign too_long    = (byte_cnt > {1'b0, longest_frame_bytes_i});
   assign ev_long     = frame_end && too_long;
   assign ev_viol     = frame_end && viol_reg;
   assign ev_align    = frame_end && !viol_reg && crc_bad && odd_nibbles;
   assign ev_fcs      = frame_end && !viol_reg && crc_bad && !odd_nibbles;
   assign ev_good     = frame_end && !viol_reg && !crc_bad && !odd_nibbles
                        && !too_long && (byte_cnt >= DA_BYTES);

   // ************************************************************
   // Address match and multicast hash filter
   // ************************************************************
   assign da_match = (da_reg[15:0] == station_addr_low_reg)
                     && (da_reg[47:16] == station_addr_high_i);
   assign mcast    = da_reg[40];
   assign bcast    = (da_reg == '1);
   always_comb begin
      accept = da_match || bcast;
      if (mcast && !bcast) begin
         accept = hash_filter_en_i ? mcast_table_reg[hash_idx_reg] : 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         frame_done_o   <= 1'b0;
         frame_accept_o <= 1'b0;
      end else begin
         frame_done_o   <= frame_end;
         frame_accept_o <= ev_good && accept;
      end
   end

   // ************************************************************
   // Statistics counters
   // ************************************************************
   assign wr_en    = pio_req_i.sel && pio_req_i.wr;
   assign ld_good  = wr_en && (pio_req_i.addr == GOOD_FRAME_COUNT_ADDR);
   assign ld_long  = wr_en && (pio_req_i.addr == OVERSIZE_FRAME_COUNT_ADDR);
   assign ld_align = wr_en && (pio_req_i.addr == MISALIGNED_FRAME_COUNT_ADDR);
   assign ld_fcs   = wr_en && (pio_req_i.addr == CRC_FAIL_COUNT_ADDR);
   assign ld_viol  = wr_en && (pio_req_i.addr == SYMBOL_ERROR_COUNT_ADDR);

   rx_stat_counter #(.WIDTH(16)) u_good_cnt (
      .ref_clk_i  (ref_clk_i),
      .rst_n_i    (rst_n_i),
      .load_i     (ld_good),
      .load_val_i (pio_req_i.wdata),
      .inc_i      (ev_good),
      .count_o    (good_cnt)
   );

   rx_stat_counter #(.WIDTH(8)) u_long_cnt (
      .ref_clk_i  (ref_clk_i),
      .rst_n_i    (rst_n_i),
      .load_i     (ld_long),
      .load_val_i (pio_req_i.wdata[7:0]),
      .inc_i      (ev_long),
      .count_o    (long_cnt)
   );

   rx_stat_counter #(.WIDTH(8)) u_align_cnt (
      .ref_clk_i  (ref_clk_i),
      .rst_n_i    (rst_n_i),
      .load_i     (ld_align),
      .load_val_i (pio_req_i.wdata[7:0]),
      .inc_i      (ev_align),
      .count_o    (align_cnt)
   );

   rx_stat_counter #(.WIDTH(8)) u_fcs_cnt (
      .ref_clk_i  (ref_clk_i),
      .rst_n_i    (rst_n_i),
      .load_i     (ld_fcs),
      .load_val_i (pio_req_i.wdata[7:0]),
      .inc_i      (ev_fcs),
      .count_o    (fcs_cnt)
   );

   rx_stat_counter #(.WIDTH(8)) u_viol_cnt (
      .ref_clk_i  (ref_clk_i),
      .rst_n_i    (rst_n_i),
      .load_i     (ld_viol),
      .load_val_i (pio_req_i.wdata[7:0]),
      .inc_i      (ev_viol),
      .count_o    (viol_cnt)
   );

   // ************************************************************
   // Programmed I/O registers
   // ************************************************************
   // Hash words are not guarded against writes while filtering is on; software must quiesce first
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         station_addr_low_reg <= STATION_ADDR_LOW_RST;
         mcast_table_reg      <= {4{MCAST_TABLE_WORD_RST}};
      end else if (wr_en) begin
         case (pio_req_i.addr)
            STATION_ADDR_LOW_ADDR:  station_addr_low_reg   <= pio_req_i.wdata;
            MCAST_TABLE_WORD3_ADDR: mcast_table_reg[63:48] <= pio_req_i.wdata;
            MCAST_TABLE_WORD2_ADDR: mcast_table_reg[47:32] <= pio_req_i.wdata;
            MCAST_TABLE_WORD1_ADDR: mcast_table_reg[31:16] <= pio_req_i.wdata;
            MCAST_TABLE_WORD0_ADDR: mcast_table_reg[15:0]  <= pio_req_i.wdata;
            default: begin
            end
         endcase
      end
   end

   // Reads answer one cycle after the select; unmapped addresses read zero
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pio_ack_o   <= 1'b0;
         pio_rdata_o <= '0;
      end else begin
         pio_ack_o   <= pio_req_i.sel;
         pio_rdata_o <= '0;
         if (pio_req_i.sel && !pio_req_i.wr) begin
            case (pio_req_i.addr)
               STATION_ADDR_LOW_ADDR:       pio_rdata_o <= station_addr_low_reg;
               GOOD_FRAME_COUNT_ADDR:       pio_rdata_o <= good_cnt;
               OVERSIZE_FRAME_COUNT_ADDR:   pio_rdata_o <= {8'h00, long_cnt};
               MISALIGNED_FRAME_COUNT_ADDR: pio_rdata_o <= {8'h00, align_cnt};
               CRC_FAIL_COUNT_ADDR:         pio_rdata_o <= {8'h00, fcs_cnt};
               RX_FSM_SNAPSHOT_ADDR:        pio_rdata_o <= {9'h000, pad_reg, proto_reg};
               SYMBOL_ERROR_COUNT_ADDR:     pio_rdata_o <= {8'h00, viol_cnt};
               MCAST_TABLE_WORD3_ADDR:      pio_rdata_o <= mcast_table_reg[63:48];
               MCAST_TABLE_WORD2_ADDR:      pio_rdata_o <= mcast_table_reg[47:32];
               MCAST_TABLE_WORD1_ADDR:      pio_rdata_o <= mcast_table_reg[31:16];
               MCAST_TABLE_WORD0_ADDR:      pio_rdata_o <= mcast_table_reg[15:0];
               default:                     pio_rdata_o <= '0;
            endcase
         end
      end
   end

endmodule

// ===== receive_side_mac_stats_checker.sv
// Concurrent checks on the receive address match and statistics block
module receive_side_mac_stats_checker
   import receive_side_mac_pkg::*;
(
   input wire logic        ref_clk_i,
   input wire logic        rst_n_i,
   input wire pio_req_s    pio_req_i,
   input wire logic [15:0] pio_rdata_o,
   input wire logic        pio_ack_o,
   input wire logic        mii_rx_dv_i,
   input wire logic        frame_done_o,
   input wire logic        frame_accept_o
);
   // ******************
   // Request decodes
   // ******************
   logic rd_c;
   logic wr_c;
   logic keep_c;
   logic cnt_c;
   assign rd_c   = pio_req_i.sel & ~pio_req_i.wr;
   assign wr_c   = pio_req_i.sel & pio_req_i.wr;
   // Only plain storage words: counters may move between write and read
   assign keep_c = pio_req_i.addr inside {STATION_ADDR_LOW_ADDR, MCAST_TABLE_WORD3_ADDR, MCAST_TABLE_WORD2_ADDR,
                                          MCAST_TABLE_WORD1_ADDR, MCAST_TABLE_WORD0_ADDR};
   assign cnt_c  = pio_req_i.addr inside {OVERSIZE_FRAME_COUNT_ADDR, MISALIGNED_FRAME_COUNT_ADDR,
                                          CRC_FAIL_COUNT_ADDR, SYMBOL_ERROR_COUNT_ADDR};
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_ack_after_req: assert property (pio_req_i.sel |=> pio_ack_o)
      else $error("request without acknowledge");
   a_no_stray_ack: assert property (!pio_req_i.sel |=> !pio_ack_o)
      else $error("acknowledge without request");
   a_idle_rdata_zero: assert property (!pio_ack_o |-> pio_rdata_o == 16'h0000)
      else $error("read data outside acknowledge");
   a_counter_width: assert property ((rd_c && cnt_c) |=> pio_rdata_o[15:8] == 8'h00)
      else $error("error counter wider than eight bits");
   a_snap_width: assert property ((rd_c && pio_req_i.addr == RX_FSM_SNAPSHOT_ADDR)
      |=> pio_rdata_o[15:7] == 9'h000) else $error("snapshot wider than seven bits");
   a_snap_idle: assert property (!mii_rx_dv_i [*4] ##0 (rd_c && pio_req_i.addr == RX_FSM_SNAPSHOT_ADDR)
      |=> pio_rdata_o[4:0] == 5'h00) else $error("protocol state not idle");
   a_reg_readback: assert property ((wr_c && keep_c) ##1 (rd_c && $stable(pio_req_i.addr))
      |=> pio_rdata_o == $past(pio_req_i.wdata, 2)) else $error("written word not read back");
   a_done_timing: assert property (frame_done_o |-> !$past(mii_rx_dv_i) && $past(mii_rx_dv_i, 2))
      else $error("frame done not one cycle after frame end");
   a_accept_with_done: assert property (frame_accept_o |-> frame_done_o)
      else $error("accept outside frame done");
endmodule

bind receive_side_mac_stats receive_side_mac_stats_checker chk (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .pio_req_i(pio_req_i), .pio_rdata_o(pio_rdata_o),
   .pio_ack_o(pio_ack_o), .mii_rx_dv_i(mii_rx_dv_i), .frame_done_o(frame_done_o),
   .frame_accept_o(frame_accept_o));

// ===== mii_phy_model.sv
// Behavioural MII transceiver that sends framed nibbles into the receive block
module mii_phy_model
   import receive_side_mac_pkg::*;
(
   input  wire logic       ref_clk_i,
   output logic            rx_dv_o,
   output logic            rx_er_o,
   output logic      [3:0] rxd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      rx_dv_o = 1'b0;
      rx_er_o = 1'b0;
      rxd_o   = 4'ha;
   end
   function automatic logic [31:0] crc_byte(logic [31:0] c, logic [7:0] b);
      for (int i = 0; i < 8; i++)
         c = (c >> 1) ^ ((c[0] ^ b[i]) ? CRC_POLY_REFL : 32'h0000_0000);
      return c;
   endfunction
   task automatic nib(logic [3:0] v, logic er);
      @(negedge ref_clk_i);
      rx_dv_o = 1'b1;
      rx_er_o = er;
      rxd_o   = v;
   endtask
   // Bad flips one FCS bit; odd adds a stray nibble; er_at marks one data nibble
   task automatic send(logic [47:0] da, int len, bit bad, bit odd, int er_at);
      logic [31:0] c;
      logic [31:0] fcs;
      logic [7:0]  b;
      c = CRC_INIT;
      fcs = 32'h0000_0000;
      repeat (15) nib(4'h5, 1'b0);
      nib(SFD_NIBBLE, 1'b0);
      for (int i = 0; i < len + 4; i++) begin
         if (i == len)
            fcs = ~c ^ {31'h0000_0000, bad};
         b = (i < 6) ? da[47-8*i -: 8] : (i < len) ? i[7:0] : fcs[8*(i-len) +: 8];
         if (i < len)
            c = crc_byte(c, b);
         nib(b[3:0], 2*i == er_at);
         nib(b[7:4], 2*i+1 == er_at);
      end
      if (odd)
         nib(4'h3, 1'b0);
      @(negedge ref_clk_i);
      rx_dv_o = 1'b0;
      rx_er_o = 1'b0;
      // Released data shows the inverse, never a stale copy
      rxd_o   = ~rxd_o;
   endtask
endmodule

// ===== receive_side_mac_stats_test.sv
// Self-checking testbench of the receive address match and statistics block
module receive_side_mac_stats_test
   import receive_side_mac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk_i;
   logic        rst_n_i;
   pio_req_s    req;
   logic [15:0] rdata;
   logic [15:0] rd;
   logic        ack;
   logic        dv;
   logic        er;
   logic [3:0]  rxd;
   logic [31:0] addr_high;
   logic [12:0] max_len;
   logic        hash_en;
   logic        done;
   logic        acc;
   logic [47:0] me;
   int          errors;
   int          checks;
   always #2 ref_clk_i = ~ref_clk_i;
   receive_side_mac_stats dut (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .pio_req_i(req), .pio_rdata_o(rdata), .pio_ack_o(ack),
      .mii_rx_dv_i(dv), .mii_rx_er_i(er), .mii_rxd_i(rxd), .station_addr_high_i(addr_high),
      .longest_frame_bytes_i(max_len), .hash_filter_en_i(hash_en), .frame_done_o(done), .frame_accept_o(acc));
   mii_phy_model phy (.ref_clk_i(ref_clk_i), .rx_dv_o(dv), .rx_er_o(er), .rxd_o(rxd));
   // ******************
   // Shared tasks
   // ******************
   task automatic close_out();
      if (errors == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic expect16(logic [15:0] got, logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
      end
   endtask
   // Called at a falling edge; request stays up until someone replaces or lowers it
   task automatic pio(logic wr, logic [31:0] a, logic [15:0] wd);
      req = '{1'b1, wr, a, wd};
      @(negedge ref_clk_i);
      expect16({15'h0000, ack}, 16'h0001);
      rd = rdata;
   endtask
   task automatic rdchk(logic [31:0] a, logic [15:0] exp);
      pio(1'b0, a, 16'h0000);
      expect16(rd, exp);
   endtask
   task automatic finish(logic exp_acc);
      int n;
      n = 0;
      while (done !== 1'b1 && n < 8) begin
         @(negedge ref_clk_i);
         n++;
      end
      expect16({14'h0000, done, acc}, {14'h0000, 1'b1, exp_acc});
      repeat (2) @(negedge ref_clk_i);
   endtask
   task automatic frame(logic [47:0] da, int len, bit bad, bit odd, int er_at, logic exp_acc);
      req.sel = 1'b0;
      phy.send(da, len, bad, odd, er_at);
      finish(exp_acc);
   endtask
   // ******************
   // Scenarios
   // ******************
   task automatic reset_values();
      for (logic [31:0] a = STATION_ADDR_LOW_ADDR; a <= MCAST_TABLE_WORD0_ADDR; a += 32'h4)
         rdchk(a, 16'h0000);
   endtask
   task automatic reg_access();
      pio(1'b1, STATION_ADDR_LOW_ADDR, 16'hbeef);
      rdchk(STATION_ADDR_LOW_ADDR, 16'hbeef);
      pio(1'b1, MISALIGNED_FRAME_COUNT_ADDR, 16'h12fe);
      rdchk(MISALIGNED_FRAME_COUNT_ADDR, 16'h00fe);
      pio(1'b1, RX_FSM_SNAPSHOT_ADDR, 16'h007f);
      rdchk(RX_FSM_SNAPSHOT_ADDR, 16'h0000);
   endtask
   task automatic good_frames();
      req.sel = 1'b0;
      fork
         phy.send(me, 60, 0, 0, -1);
         begin
            repeat (60) @(negedge ref_clk_i);
            rdchk(RX_FSM_SNAPSHOT_ADDR, {9'h000, PAD_SHORT, PROTO_DATA});
            req.sel = 1'b0;
         end
      join
      finish(1'b1);
      frame({addr_high, 16'hbeee}, 60, 0, 0, -1, 1'b0);
      frame({addr_high ^ 32'h0000_0001, 16'hbeef}, 60, 0, 0, -1, 1'b0);
      rdchk(GOOD_FRAME_COUNT_ADDR, 16'h0003);
   endtask
   task automatic error_frames();
      frame(me, 60, 1, 0, -1, 1'b0);
      rdchk(CRC_FAIL_COUNT_ADDR, 16'h0001);
      frame(me, 60, 1, 1, -1, 1'b0);
      rdchk(MISALIGNED_FRAME_COUNT_ADDR, 16'h00ff);
      frame(me, 60, 1, 0, 40, 1'b0);
      rdchk(SYMBOL_ERROR_COUNT_ADDR, 16'h0001);
      rdchk(CRC_FAIL_COUNT_ADDR, 16'h0001);
      rdchk(MISALIGNED_FRAME_COUNT_ADDR, 16'h00ff);
      pio(1'b1, CRC_FAIL_COUNT_ADDR, 16'h00ff);
      frame(me, 60, 1, 0, -1, 1'b0);
      rdchk(CRC_FAIL_COUNT_ADDR, 16'h0000);
   endtask
   // 60 bytes plus FCS is 64: one over, then exactly at the limit
   task automatic oversize();
      max_len = 13'h003f;
      frame(me, 60, 0, 0, -1, 1'b0);
      rdchk(OVERSIZE_FRAME_COUNT_ADDR, 16'h0001);
      max_len = 13'h0040;
      frame(me, 60, 0, 0, -1, 1'b1);
      rdchk(OVERSIZE_FRAME_COUNT_ADDR, 16'h0001);
   endtask
   task automatic hash_filter();
      logic [47:0] mc;
      logic [31:0] c;
      logic [31:0] ha;
      logic [15:0] hb;
      mc = 48'h0100_5e00_0007;
      c = CRC_INIT;
      frame(mc, 60, 0, 0, -1, 1'b1);
      hash_en = 1'b1;
      frame(mc, 60, 0, 0, -1, 1'b0);
      frame('1, 60, 0, 0, -1, 1'b1);
      hash_en = 1'b0;
      for (int i = 0; i < 6; i++)
         c = phy.crc_byte(c, mc[47-8*i -: 8]);
      ha = MCAST_TABLE_WORD0_ADDR - {28'h0000000, c[5:4], 2'b00};
      hb = 16'h0001 << c[3:0];
      pio(1'b1, ha, hb);
      rdchk(ha, hb);
      hash_en = 1'b1;
      frame(mc, 60, 0, 0, -1, 1'b1);
      rdchk(GOOD_FRAME_COUNT_ADDR, 16'h0008);
   endtask
   // Counters that have moved must come back to zero on a reset in mid-run
   task automatic mid_reset();
      req.sel = 1'b0;
      rst_n_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      rdchk(GOOD_FRAME_COUNT_ADDR, 16'h0000);
      rdchk(MISALIGNED_FRAME_COUNT_ADDR, 16'h0000);
   endtask
   initial begin
      ref_clk_i = 1'b0;
      rst_n_i = 1'b0;
      req = '0;
      addr_high = 32'h0a1b_2c3d;
      max_len = LONGEST_FRAME_BYTES_RST;
      hash_en = 1'b0;
      me = {32'h0a1b_2c3d, 16'hbeef};
      errors = 0;
      checks = 0;
      repeat (16) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      reset_values();
      reg_access();
      good_frames();
      error_frames();
      oversize();
      hash_filter();
      mid_reset();
      close_out();
   end
   // Whole run is thirteen frames of under 200 cycles each
   initial begin
      #50us;
      errors++;
      close_out();
   end
endmodule
